// >>> lmr_pkg.sv
package lmr_pkg;

    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int NUM_ROWS = 8;
    localparam int NUM_COLS = 44;
    localparam logic [5:0] COLS_MUX8 = 6'h28;   // 40 columns
    localparam logic [5:0] COLS_MUX6 = 6'h2a;   // 42 columns
    localparam logic [5:0] COLS_MUX4 = 6'h2c;   // 44 columns
    localparam logic [3:0] ROWS_MUX8 = 4'h8;
    localparam logic [3:0] ROWS_MUX6 = 4'h6;
    localparam logic [3:0] ROWS_MUX4 = 4'h4;
    localparam logic [5:0] PTR_RESET = 6'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 125_000_000;
    localparam int FRAME_HZ_DEFAULT = 200;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LMR_MUX8 = 2'b00,
        LMR_MUX6 = 2'b01,
        LMR_MUX4 = 2'b10
    } lmr_mux_t;

    typedef enum logic [1:0] {
        LMR_BIAS_Q = 2'b00,   // one-quarter bias
        LMR_BIAS_H = 2'b01,   // half bias
        LMR_BIAS_T = 2'b10    // one-third bias
    } lmr_bias_t;

    localparam logic [1:0] A_HALF  = 2'h1;
    localparam logic [1:0] A_THIRD = 2'h2;
    localparam logic [1:0] A_QUART = 2'h3;

    // config bundle from the command layer
    typedef struct packed {
        logic      enable;
        lmr_mux_t  mux;
        lmr_bias_t bias;
    } lmr_cfg_t;

    // drive bundle toward the analog voltage selector
    typedef struct packed {
        logic [7:0]  bp_sel;     // backplane currently selected
        logic [7:0]  bp_act;     // backplane in active range
        logic [43:0] seg_on;     // segment data for current row
        logic [43:0] seg_act;    // segment in active range
        logic [1:0]  bias_a;     // bias parameter a
    } lmr_drive_t;

endpackage

// >>> lmr_top.sv
`timescale 1ns/100ps

// ------------------------------------------------------------------------
// byte fifo
// ------------------------------------------------------------------------
module lmr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // storage
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

    // pointers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule

// ------------------------------------------------------------------------
// display ram and scan
// ------------------------------------------------------------------------
// Notes on behaviour
// - backplanes active per mode: 8, 6, 4
// - active segments 40, 42, 44 per mode
// - ram is 40x8, 42x6, 44x4 per mode
// - ram one is element on, zero off
// - row k to backplane k, column to segment
// - store nibbles, six bits or bytes per mode
// - separate display register holds scanned data
// - segment drive from phase and display register
// - bias a is 1, 2, 3 for half, third, quarter
// - reset disables, outputs low, 1:8 quarter bias
// - pointer steps two, one-or-two, one per mode
// - pointer stops at end, surplus discarded
module lmr_top #(
    parameter int FRAME_HZ    = lmr_pkg::FRAME_HZ_DEFAULT,
    parameter int SLOT_CYCLES = lmr_pkg::CLK_HZ
                                / (FRAME_HZ * lmr_pkg::NUM_ROWS)
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire lmr_pkg::lmr_cfg_t cfg,
    input  wire logic              ptr_load,
    input  wire logic [5:0]        ptr_value,
    input  wire logic              byte_valid,
    output logic                   byte_ready,
    input  wire logic [7:0]        byte_data,
    output lmr_pkg::lmr_drive_t    drive
);
    localparam int NR = lmr_pkg::NUM_ROWS;
    localparam int NC = lmr_pkg::NUM_COLS;

    logic [NR-1:0] ram [NC];        // column-major bitmap
    logic [NR-1:0] disp [NC];       // display register
    logic [5:0]    ptr;
    logic          ptr_ok;          // pointer in range
    logic [2:0]    six_off;         // bits already in column, 1:6 mode
    logic [5:0]    ncols;
    logic [3:0]    nrows;
    logic          f_valid;
    logic          f_ready;
    logic [7:0]    f_data;
    logic [31:0]   slot_cnt;
    logic [2:0]    row;
    logic          slot_end;
    logic          frame_end;

    lmr_fifo #(.WIDTH(8), .DEPTH(lmr_pkg::FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (byte_valid),
        .in_ready  (byte_ready),
        .in_data   (byte_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    // mode geometry
    always_comb
    begin
        case (cfg.mux)
            lmr_pkg::LMR_MUX6:
            begin
                ncols = lmr_pkg::COLS_MUX6;
                nrows = lmr_pkg::ROWS_MUX6;
            end
            lmr_pkg::LMR_MUX4:
            begin
                ncols = lmr_pkg::COLS_MUX4;
                nrows = lmr_pkg::ROWS_MUX4;
            end
            default:
            begin
                ncols = lmr_pkg::COLS_MUX8;
                nrows = lmr_pkg::ROWS_MUX8;
            end
        endcase
    end

    // ram writes drain one byte per cycle; bytes past the end are
    // still popped so the host is never stalled forever
    assign f_ready = 1'b1;

    // ram fill and pointer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ptr     <= lmr_pkg::PTR_RESET;
            ptr_ok  <= 1'b1;
            six_off <= 3'h0;
        end
        else if (ptr_load)
        begin
            ptr     <= ptr_value;
            ptr_ok  <= ptr_value < ncols; // out-of-range load still sets ptr, but the bytes after it are discarded
            six_off <= 3'h0;
        end
        else if (f_valid && ptr_ok)
        begin
            case (cfg.mux)
                lmr_pkg::LMR_MUX4:
                begin
                    ram[ptr][3:0] <= f_data[3:0];
                    if (ptr + 6'h1 < ncols)
                        ram[ptr + 6'h1][3:0] <= f_data[7:4];
                    if (ptr + 6'h2 < ncols)
                        ptr <= ptr + 6'h2;
                    else
                        ptr_ok <= 1'b0;
                end
                lmr_pkg::LMR_MUX6:
                begin
                    // sextuples: byte finishes this column, rest wraps
                    for (int b = 0; b < 8; b++)
                    begin
                        if (int'(six_off) + b < 6)
                            ram[ptr][int'(six_off) + b] <= f_data[b];
                        else if (int'(six_off) + b < 12
                                 && ptr + 6'h1 < ncols)
                            ram[ptr + 6'h1][int'(six_off) + b - 6]
                                <= f_data[b];
                    end
                    if (six_off >= 3'h4)
                    begin
                        six_off <= six_off - 3'h4;
                        if (ptr + 6'h2 < ncols)
                            ptr <= ptr + 6'h2;
                        else
                            ptr_ok <= 1'b0;
                    end
                    else
                    begin
                        six_off <= six_off + 3'h2;
                        if (ptr + 6'h1 < ncols)
                            ptr <= ptr + 6'h1;
                        else
                            ptr_ok <= 1'b0;
                    end
                end
                default:
                begin
                    ram[ptr] <= f_data;
                    if (ptr + 6'h1 < ncols)
                        ptr <= ptr + 6'h1;
                    else
                        ptr_ok <= 1'b0;
                end
            endcase
        end
    end

    // row slot timer
    assign slot_end  = slot_cnt == 32'(SLOT_CYCLES - 1);
    assign frame_end = slot_end && ({1'b0, row} == nrows - 4'h1);

    always_ff @(posedge clk)
    begin
        if (!rst_n || !cfg.enable)
        begin
            slot_cnt <= '0;
            row      <= 3'h0;
        end
        else if (slot_end)
        begin
            slot_cnt <= '0;
            row      <= frame_end ? 3'h0 : row + 3'h1;
        end
        else
            slot_cnt <= slot_cnt + 32'h1;
    end

    // display register reloads at frame boundaries, and on every cycle while
    // disabled, so a frame never shows a half-written image
    always_ff @(posedge clk)
    begin
        if (!cfg.enable || frame_end)
            for (int c = 0; c < NC; c++)
                disp[c] <= ram[c];
    end

    // drive outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n || !cfg.enable)
            drive <= '0;
        else
        begin
            for (int r = 0; r < NR; r++)
            begin
                drive.bp_act[r] <= r < int'(nrows);
                drive.bp_sel[r] <= (r == int'(row));
            end
            for (int c = 0; c < NC; c++)
            begin
                drive.seg_act[c] <= c < int'(ncols);
                drive.seg_on[c]  <= (c < int'(ncols))
                                    && disp[c][row];
            end
            case (cfg.bias)
                lmr_pkg::LMR_BIAS_H: drive.bias_a <= lmr_pkg::A_HALF;
                lmr_pkg::LMR_BIAS_T: drive.bias_a <= lmr_pkg::A_THIRD;
                default:             drive.bias_a <= lmr_pkg::A_QUART;
            endcase
        end
    end
endmodule

// >>> lmr_monitor.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// scan output checker
// ------------------------------------------------------------
module lmr_monitor #(
    parameter int SLOT_CYCLES = 4
) (
    input wire logic                clk,
    input wire logic                rst_n,
    input wire lmr_pkg::lmr_cfg_t   cfg,
    input wire lmr_pkg::lmr_drive_t drive
);
    logic [7:0]  bpa;
    logic [7:0]  nx;
    logic [7:0]  prev;
    logic [43:0] sga;
    logic [1:0]  av;
    logic [31:0] run;    // cycles the current row select has stood

    // expected ranges, bias and next row; mux code 11 is never driven
    assign bpa = ~(8'hff << (8 - 2 * cfg.mux));
    assign sga = ~(44'hfff_ffff_ffff << (40 + 2 * cfg.mux));
    assign av = cfg.bias == lmr_pkg::LMR_BIAS_Q ? 2'h3 : cfg.bias;
    assign nx = (prev & (bpa ^ (bpa >> 1))) != 8'h00 ? 8'h01 : prev << 1;

    // row select one clock back
    always_ff @(posedge clk)
        prev <= drive.bp_sel;

    // slot length counter; restarts when the row select moves, so a
    // real-rate slot needs no huge sequence delay
    always_ff @(posedge clk)
    begin
        if (!rst_n || drive.bp_sel != prev)
            run <= 32'h1;
        else
            run <= run + 32'h1;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // mode held, so registered outputs have caught up
    sequence s_steady;
        (cfg.enable && $stable(cfg)) [*3];
    endsequence
    sequence s_off;
        !cfg.enable ##1 !cfg.enable;
    endsequence
    // a row handed on from another row, not from blank
    sequence s_enter;
        drive.bp_sel != prev && prev != 8'h00 && drive.bp_sel != 8'h00;
    endsequence

    property p_bp_act; s_steady |-> drive.bp_act == bpa; endproperty
    a_bp_act: assert property (p_bp_act)
        else $error("backplane range wrong");
    property p_seg_act; s_steady |-> drive.seg_act == sga; endproperty
    a_seg_act: assert property (p_seg_act)
        else $error("segment range wrong");
    property p_bias; s_steady |-> drive.bias_a == av; endproperty
    a_bias: assert property (p_bias)
        else $error("bias parameter wrong");
    property p_off; s_off |-> drive == '0; endproperty
    a_off: assert property (p_off)
        else $error("outputs not low while off");
    property p_sel_in;
        drive.bp_sel != 8'h00 |->
            $onehot(drive.bp_sel) && (drive.bp_sel & ~drive.bp_act) == 8'h00;
    endproperty
    a_sel_in: assert property (p_sel_in)
        else $error("row select outside range");
    property p_seg_in; (drive.seg_on & ~drive.seg_act) == 44'h0; endproperty
    a_seg_in: assert property (p_seg_in)
        else $error("data on inactive segment");
    property p_step; s_enter |-> drive.bp_sel == nx; endproperty
    a_step: assert property (p_step)
        else $error("row order wrong");
    property p_slot;
        disable iff (!rst_n || !cfg.enable)
        s_enter |-> run == 32'(SLOT_CYCLES);
    endproperty
    a_slot: assert property (p_slot)
        else $error("row slot length wrong");
endmodule

bind lmr_top lmr_monitor #(.SLOT_CYCLES(SLOT_CYCLES)) i_mon (.clk(clk),
    .rst_n(rst_n), .cfg(cfg), .drive(drive));

// >>> lmr_panel.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// panel model
// ------------------------------------------------------------
module lmr_panel (
    input wire logic                clk,
    input wire lmr_pkg::lmr_drive_t drive,
    output logic [7:0][43:0]        pix
);
    // a row shows segment data while its backplane is selected; it
    // keeps every segment so stray data beyond the range is seen
    always_ff @(posedge clk)
    begin
        for (int k = 0; k < 8; k++)
            if (drive.bp_sel[k])
                pix[k] <= drive.seg_on;
    end
endmodule

// >>> lmr_tb.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// scan bench
// ------------------------------------------------------------
module testbench;
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    lmr_pkg::lmr_cfg_t   cfg = '0;
    logic                ptr_load = 1'b0;
    logic [5:0]          ptr_value = 6'h00;
    logic                byte_valid = 1'b0;
    logic                byte_ready;
    logic [7:0]          byte_data = 8'h00;
    lmr_pkg::lmr_drive_t drive;
    logic [7:0][43:0]    pix;
    logic [7:0][43:0]    img;
    int                  n_fail = 0;
    int                  checks_done = 0;
    int                  pos;
    int                  nr;

    always #4 clk = ~clk;

    lmr_top #(.SLOT_CYCLES(4)) i_dut (.clk(clk), .rst_n(rst_n), .cfg(cfg),
        .ptr_load(ptr_load), .ptr_value(ptr_value), .byte_valid(byte_valid),
        .byte_ready(byte_ready), .byte_data(byte_data), .drive(drive));
    lmr_panel i_panel (.clk(clk), .drive(drive), .pix(pix));

    task chk(string nm, logic [43:0] got, logic [43:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    task report_and_stop;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // display off while the mode changes; the ram must be refilled
    task set_mode(lmr_pkg::lmr_mux_t m, lmr_pkg::lmr_bias_t b, int n);
        cfg.enable = 1'b0;
        repeat (4) @(posedge clk);
        #1 cfg = '{1'b1, m, b};
        nr = n;
        img = '0;
    endtask

    // bytes form one bit stream over nr-bit columns from column p
    task fill(bit ld, int p, int cnt, int s);
        int         g;
        logic [7:0] b;
        if (ld)
        begin
            ptr_load = 1'b1;
            ptr_value = 6'(p);
            pos = p * nr;
            @(posedge clk);
            #1 ptr_load = 1'b0;
        end
        for (int j = 0; j < cnt; j++)
        begin
            b = 8'(j * 29 + s);
            byte_valid = 1'b1;
            byte_data = b;
            for (g = 0; g < 50 && byte_ready !== 1'b1; g++)
                @(negedge clk);
            if (g == 50)
                n_fail++;
            @(posedge clk);
            #1;
            for (int i = 0; i < 8; i++)
                if ((pos + i) / nr < 48 - nr)
                    img[(pos + i) % nr][(pos + i) / nr] = b[i];
            pos += 8;
        end
        byte_valid = 1'b0;
        // several frames, so the display register has been reloaded
        repeat (120) @(posedge clk);
        #1;
        for (int k = 0; k < nr; k++)
            chk("row", pix[k], img[k]);
    endtask

    task t_reset;
        chk("rst", drive.seg_on | 44'(drive.bp_sel), 44'h0);
        chk("rst_seg", drive.seg_act, 44'h0);
        chk("rst_bp", 44'({drive.bp_act, drive.bias_a}), 44'h0);
        $display("reset test done");
    endtask

    task t_mux8;
        set_mode(lmr_pkg::LMR_MUX8, lmr_pkg::LMR_BIAS_Q, 8);
        fill(1, 0, 40, 3);
        fill(0, 0, 2, 5);
        fill(1, 39, 1, 9);
        fill(1, 40, 1, 7);
        $display("mode 1:8 test done");
    endtask

    task t_mux6;
        set_mode(lmr_pkg::LMR_MUX6, lmr_pkg::LMR_BIAS_T, 6);
        fill(1, 0, 32, 2);
        fill(1, 41, 1, 5);
        fill(1, 5, 3, 9);
        $display("mode 1:6 test done");
    endtask

    task t_mux4;
        set_mode(lmr_pkg::LMR_MUX4, lmr_pkg::LMR_BIAS_H, 4);
        fill(1, 0, 22, 1);
        fill(0, 0, 1, 4);
        fill(1, 43, 1, 6);
        fill(1, 10, 3, 8);
        $display("mode 1:4 test done");
    endtask

    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset;
        t_mux8;
        t_mux6;
        t_mux4;
        report_and_stop;
    end

    // watchdog, well beyond the roughly 1,460 cycles the tests need
    initial
    begin
        repeat (10000) @(posedge clk);
        n_fail++;
        report_and_stop;
    end
endmodule
